// ==== pkg/usdp_pkg.sv ====
package usdp_pkg;
    // ************************************************************
    // register map, byte addresses on the apb bus
    // ************************************************************
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATA = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_CTRLB = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_CTRLC = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_BAUD = 5'h10;

    // status register a fields
    localparam int STA_DOUBLE = 0;
    localparam int STA_EMPTY = 5;
    localparam int STA_DONE = 6;
    localparam int STA_RXFULL = 7;
    // control register b fields
    localparam int CTB_TX9 = 0;
    localparam int CTB_RX9 = 1;
    localparam int CTB_SIZE2 = 2;
    localparam int CTB_TRANSMIT_ENABLE = 3;
    localparam int CTB_RECEIVE_ENABLE = 4;
    localparam int CTB_EMPTYIE = 5;
    localparam int CTB_DONEIE = 6;
    // control register c fields
    localparam int CTC_POL = 0;
    localparam int CTC_SIZE_LO = 1;
    localparam int CTC_STOP2 = 3;
    localparam int CTC_PAR_LO = 4;
    localparam int CTC_SYNC = 6;
    localparam int CTC_MASTER = 7;

    // ************************************************************
    // widths, codes and timing counts
    // ************************************************************
    localparam int BAUD_W = 12;
    localparam int DATA_W = 9;
    localparam int FRAME_W = 13;
    localparam logic [4:0] OSC_NORMAL = 5'h10;
    localparam logic [4:0] OSC_DOUBLE = 5'h08;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [2:0] SIZE_EIGHT = 3'h3;
    localparam logic [3:0] BITS_MIN = 4'h5;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;

    typedef struct packed {
        logic [2:0] sizeCode;
        logic [1:0] parityMode;
        logic twoStop;
        logic syncMode;
        logic xckMaster;
        logic clkPol;
    } usdp_cfg_t;

    typedef enum {TX_IDLE, TX_SHIFT} usdp_tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA} usdp_rx_state_t;

    // number of data bits for a character size code
    function automatic logic [3:0] usdp_data_bits(input logic [2:0] code);
        if (code == SIZE_NINE) begin
            return BITS_NINE;
        end else if (code > SIZE_EIGHT) begin
            return BITS_EIGHT;
        end
        return BITS_MIN + {1'b0, code};
    endfunction
endpackage

// ==== hw/usdp_sync3.sv ====
// three-stage pin synchroniser; level moves only when stages two and three agree
module usdp_sync3 (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic stage1;
    logic stage2;
    logic stage3;

    // stage1 feeds stage2 only, keeping metastability off the decision logic
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
            level <= 1'b1;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end

    // edges of the filtered level, one cycle each
    assign rise = (stage2 == stage3) && stage3 && !level;
    assign fall = (stage2 == stage3) && !stage3 && level;
endmodule

// ==== hw/usdp_datapath.sv ====
import usdp_pkg::*;

// Overview of operation
// - tx enable takes output pin for transmitter
// - sync mode: transmitter times bits by clock pin
// - data register write loads buffer, starts send
// - buffer moves to idle or finishing shifter
// - narrow characters drop upper written bits
// - empty flag high exactly while buffer empty
// - data register write clears empty flag
// - empty interrupt requested while flag set
// - complete flag set when frame out, buffer empty
// - complete flag cleared by service or one-write
// - complete interrupt raised when flag sets
// - parity bit after data, before stop
// - disable waits for buffer and shifter empty
// - rx enable takes input pin for receiver
// - sync mode: receiver clocked by clock pin
// - start bit begins frame, bits sampled in
// - second stop bit ignored by receiver
// - first stop bit moves frame to buffer
// - narrow characters read with zero upper bits
// - start low, data lsb first, parity, stops high
// - parity is xor of data, inverted odd
// - async divider sixteen, eight double speed
// - receive flag high while buffer unread
module usdp_datapath (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [usdp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic serialOutputPin,
    output logic serialOutputPinOeN,
    input wire logic serialInputPin,
    output logic serialInputOwned,
    input wire logic serialClockPinIn,
    output logic serialClockPinOut,
    output logic serialClockPinOeN,
    input wire logic completeIrqAck,
    output logic emptyIrq,
    output logic completeIrq
);
    import usdp_pkg::*;

    // ************************************************************
    // registers and flags
    // ************************************************************
    usdp_cfg_t cfg;
    logic [BAUD_W-1:0] baudDiv;
    logic doubleSpeed, txEnable, rxEnable, emptyIe, completeIe, ninthTx;
    logic txBufFull, txDoneFlag, rxFull, txEnEff, xckLevel;
    logic [DATA_W-1:0] txBuf, rxBuf;
    usdp_tx_state_t txState;
    usdp_rx_state_t rxState;
    logic [FRAME_W-1:0] txShift;
    logic [3:0] txLeft, rxCnt;
    logic [4:0] txOsc, rxOsc;
    logic [BAUD_W-1:0] baudCnt;
    logic [DATA_W-1:0] rxData;

    // ************************************************************
    // apb decode, zero wait states
    // ************************************************************
    wire xfer = psel && penable;
    wire wrData = xfer && pwrite && (paddr == ADDR_DATA);
    wire wrStatA = xfer && pwrite && (paddr == ADDR_STATA);
    wire wrCtrlB = xfer && pwrite && (paddr == ADDR_CTRLB);
    wire wrCtrlC = xfer && pwrite && (paddr == ADDR_CTRLC);
    wire wrBaud = xfer && pwrite && (paddr == ADDR_BAUD);
    wire rdData = xfer && !pwrite && (paddr == ADDR_DATA);
    wire mapped = (paddr == ADDR_DATA) || (paddr == ADDR_STATA) || (paddr == ADDR_CTRLB)
        || (paddr == ADDR_CTRLC) || (paddr == ADDR_BAUD);
    assign pready = 1'b1;

    // ************************************************************
    // clocking: baud divider, oversampling and clock pin
    // ************************************************************
    logic xckRise, xckFall;
    usdp_sync3 xckSync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin(serialClockPinIn),
        .level(),
        .rise(xckRise),
        .fall(xckFall)
    );
    wire baudTick = (baudCnt == baudDiv);
    wire [4:0] oscLen = doubleSpeed ? OSC_DOUBLE : OSC_NORMAL;
    wire [4:0] oscHalf = oscLen >> 1;
    wire masterMode = cfg.syncMode && cfg.xckMaster;
    wire edgeRise = masterMode ? (baudTick && !xckLevel) : xckRise;
    wire edgeFall = masterMode ? (baudTick && xckLevel) : xckFall;
    // polarity picks which edge moves data and which samples it
    wire changeEdge = cfg.clkPol ? edgeFall : edgeRise;
    wire sampleEdge = cfg.clkPol ? edgeRise : edgeFall;

    // divider runs free; the master clock pin toggles every tick
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            baudCnt <= '0;
            xckLevel <= 1'b0;
        end else begin
            baudCnt <= baudTick ? '0 : baudCnt + 1'b1;
            if (baudTick && masterMode) begin
                xckLevel <= !xckLevel;
            end
        end
    end
    assign serialClockPinOut = xckLevel;
    assign serialClockPinOeN = !(masterMode && (txEnEff || rxEnable));

    // ************************************************************
    // transmit frame assembly
    // ************************************************************
    wire [3:0] nBits = usdp_data_bits(cfg.sizeCode);
    wire parityOn = cfg.parityMode[1];
    logic [DATA_W-1:0] txMasked;
    logic [FRAME_W-1:0] frameBits;
    logic txParity;
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            txMasked[i] = (i < nBits) ? txBuf[i] : 1'b0;
        end
        txParity = (^txMasked) ^ cfg.parityMode[0];
        frameBits = '1;
        frameBits[0] = 1'b0;
        for (int i = 0; i < DATA_W; i++) begin
            if (i < nBits) begin
                frameBits[i+1] = txMasked[i];
            end
        end
        if (parityOn) begin
            frameBits[nBits+4'h1] = txParity;
        end
    end
    wire [3:0] frameLen = 4'h2 + nBits + {3'h0, parityOn} + {3'h0, cfg.twoStop};

    // ************************************************************
    // transmit shifter
    // ************************************************************
    wire txBitTick = cfg.syncMode ? changeEdge : (baudTick && (txOsc == oscLen - 5'h1));
    wire lastBit = (txState == TX_SHIFT) && txBitTick && (txLeft == 4'h1);
    // idle shifter, or straight after the final stop bit
    wire txLoad = txEnEff && txBufFull && ((txState == TX_IDLE) || lastBit);
    wire txDoneSet = lastBit && !txBufFull;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txState <= TX_IDLE;
            txShift <= '1;
            txLeft <= '0;
            txOsc <= '0;
        end else if (txLoad) begin
            txState <= TX_SHIFT;
            txShift <= frameBits;
            txLeft <= frameLen;
            txOsc <= '0;
        end else if (txState == TX_SHIFT) begin
            if (baudTick) begin
                txOsc <= (txOsc == oscLen - 5'h1) ? '0 : txOsc + 5'h1;
            end
            if (txBitTick) begin
                txShift <= {1'b1, txShift[FRAME_W-1:1]};
                txLeft <= txLeft - 4'h1;
                if (txLeft == 4'h1) begin
                    txState <= TX_IDLE;
                end
            end
        end
    end

    // output owned until the last pending bit has left
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txEnEff <= 1'b0;
        end else if (txEnable) begin
            txEnEff <= 1'b1;
        end else if (!txBufFull && (txState == TX_IDLE)) begin
            txEnEff <= 1'b0;
        end
    end
    assign serialOutputPin = (txState == TX_SHIFT) ? txShift[0] : 1'b1;
    assign serialOutputPinOeN = !txEnEff;

    // ************************************************************
    // receive path
    // ************************************************************
    logic rxLevel;
    usdp_sync3 rxSync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin(serialInputPin),
        .level(rxLevel),
        .rise(),
        .fall()
    );
    assign serialInputOwned = rxEnable;
    wire rxSampleTick = cfg.syncMode ? sampleEdge : (baudTick && (rxOsc == oscLen - 5'h1));
    wire [3:0] rxLast = nBits + {3'h0, parityOn};
    wire rxFrameDone = (rxState == RX_DATA) && rxSampleTick && (rxCnt == rxLast);

    // receiver returns to idle after the first stop bit, so a second one is just idle line
    always_ff @(posedge sys_clk) begin
        if (reset || !rxEnable) begin
            rxState <= RX_IDLE;
            rxOsc <= '0;
            rxCnt <= '0;
            rxData <= '0;
        end else begin
            case (rxState)
                RX_IDLE: begin
                    rxOsc <= '0;
                    rxCnt <= '0;
                    rxData <= '0;
                    if (!rxLevel && cfg.syncMode && sampleEdge) begin
                        rxState <= RX_DATA;
                    end else if (!rxLevel && !cfg.syncMode) begin
                        rxState <= RX_START;
                    end
                end
                RX_START: begin
                    if (baudTick) begin
                        rxOsc <= rxOsc + 5'h1;
                        if (rxOsc == oscHalf - 5'h1) begin
                            rxOsc <= '0;
                            // a start bit gone high by mid-bit was a glitch
                            rxState <= rxLevel ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (baudTick) begin
                        rxOsc <= (rxOsc == oscLen - 5'h1) ? '0 : rxOsc + 5'h1;
                    end
                    if (rxSampleTick) begin
                        if (rxCnt < nBits) begin
                            rxData[rxCnt] <= rxLevel;
                        end
                        rxCnt <= rxCnt + 4'h1;
                        if (rxCnt == rxLast) begin
                            rxState <= RX_IDLE;
                        end
                    end
                end
                default: rxState <= RX_IDLE;
            endcase
        end
    end

    // single-entry buffer; a new frame overwrites unread data
    always_ff @(posedge sys_clk) begin
        if (reset || !rxEnable) begin
            rxFull <= 1'b0;
            rxBuf <= '0;
        end else if (rxFrameDone) begin
            rxFull <= 1'b1;
            rxBuf <= rxData;
        end else if (rdData) begin
            rxFull <= 1'b0;
        end
    end

    // ************************************************************
    // software registers and transmit flags
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg <= '0;
            baudDiv <= '0;
            doubleSpeed <= 1'b0;
            txEnable <= 1'b0;
            rxEnable <= 1'b0;
            emptyIe <= 1'b0;
            completeIe <= 1'b0;
            ninthTx <= 1'b0;
            txBuf <= '0;
        end else begin
            if (wrStatA) begin
                doubleSpeed <= pwdata[STA_DOUBLE];
            end
            if (wrCtrlB) begin
                ninthTx <= pwdata[CTB_TX9];
                cfg.sizeCode[2] <= pwdata[CTB_SIZE2];
                txEnable <= pwdata[CTB_TRANSMIT_ENABLE];
                rxEnable <= pwdata[CTB_RECEIVE_ENABLE];
                emptyIe <= pwdata[CTB_EMPTYIE];
                completeIe <= pwdata[CTB_DONEIE];
            end
            if (wrCtrlC) begin
                cfg.clkPol <= pwdata[CTC_POL];
                cfg.sizeCode[1:0] <= pwdata[CTC_SIZE_LO +: 2];
                cfg.twoStop <= pwdata[CTC_STOP2];
                cfg.parityMode <= pwdata[CTC_PAR_LO +: 2];
                cfg.syncMode <= pwdata[CTC_SYNC];
                cfg.xckMaster <= pwdata[CTC_MASTER];
            end
            if (wrBaud) begin
                baudDiv <= pwdata[BAUD_W-1:0];
            end
            if (wrData) begin
                txBuf <= {ninthTx, pwdata[7:0]};
            end
        end
    end

    // buffer state: a write beats a same-cycle handoff; done flag set beats its clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txBufFull <= 1'b0;
            txDoneFlag <= 1'b0;
        end else begin
            if (wrData) begin
                txBufFull <= 1'b1;
            end else if (txLoad) begin
                txBufFull <= 1'b0;
            end
            if (txDoneSet) begin
                txDoneFlag <= 1'b1;
            end else if (completeIrqAck || (wrStatA && pwdata[STA_DONE])) begin
                txDoneFlag <= 1'b0;
            end
        end
    end
    wire emptyFlag = !txBufFull;
    assign emptyIrq = emptyIe && emptyFlag;
    assign completeIrq = completeIe && txDoneFlag;

    // ************************************************************
    // read data, registered in the setup phase
    // ************************************************************
    logic [31:0] readMux;
    always_comb begin
        readMux = '0;
        if (paddr == ADDR_DATA) begin
            readMux[DATA_W-2:0] = rxBuf[DATA_W-2:0];
        end else if (paddr == ADDR_STATA) begin
            readMux[STA_DOUBLE] = doubleSpeed;
            readMux[STA_EMPTY] = emptyFlag;
            readMux[STA_DONE] = txDoneFlag;
            readMux[STA_RXFULL] = rxFull;
        end else if (paddr == ADDR_CTRLB) begin
            readMux[CTB_TX9] = ninthTx;
            readMux[CTB_RX9] = rxBuf[DATA_W-1];
            readMux[CTB_SIZE2] = cfg.sizeCode[2];
            readMux[CTB_TRANSMIT_ENABLE] = txEnable;
            readMux[CTB_RECEIVE_ENABLE] = rxEnable;
            readMux[CTB_EMPTYIE] = emptyIe;
            readMux[CTB_DONEIE] = completeIe;
        end else if (paddr == ADDR_CTRLC) begin
            readMux[CTC_POL] = cfg.clkPol;
            readMux[CTC_SIZE_LO +: 2] = cfg.sizeCode[1:0];
            readMux[CTC_STOP2] = cfg.twoStop;
            readMux[CTC_PAR_LO +: 2] = cfg.parityMode;
            readMux[CTC_SYNC] = cfg.syncMode;
            readMux[CTC_MASTER] = cfg.xckMaster;
        end else if (paddr == ADDR_BAUD) begin
            readMux[BAUD_W-1:0] = baudDiv;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? '0 : readMux;
            pslverr <= !mapped;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_write_clears_empty: assert property (@(posedge sys_clk) disable iff (reset)
        wrData |=> !emptyFlag) else $error("empty flag still set after data write");
    a_empty_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
        (emptyIe && !txBufFull && !wrData && !wrCtrlB) |=> emptyIrq) else $error("empty request dropped");
    a_done_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
        (lastBit && !txBufFull) |=> txDoneFlag) else $error("complete flag not set");
    a_done_flag_clear: assert property (@(posedge sys_clk) disable iff (reset)
        (completeIrqAck && !txDoneSet) |=> !txDoneFlag) else $error("complete flag not cleared");
    a_done_irq_raise: assert property (@(posedge sys_clk) disable iff (reset)
        ($rose(txDoneFlag) && completeIe) |-> completeIrq) else $error("complete request missing");
    a_start_bit_low: assert property (@(posedge sys_clk) disable iff (reset)
        txLoad |=> (!serialOutputPin && !serialOutputPinOeN)) else $error("start bit not low");
    a_idle_line_high: assert property (@(posedge sys_clk) disable iff (reset)
        (txState == TX_IDLE) |-> serialOutputPin) else $error("idle line not high");
    a_disable_holds_pin: assert property (@(posedge sys_clk) disable iff (reset)
        (txEnEff && (txBufFull || txState == TX_SHIFT)) |=> !serialOutputPinOeN)
        else $error("output released with data pending");
    a_rx_flush: assert property (@(posedge sys_clk) disable iff (reset)
        !rxEnable |=> !rxFull) else $error("receive flag kept while disabled");
    a_frame_to_buffer: assert property (@(posedge sys_clk) disable iff (reset)
        (rxFrameDone && rxEnable) |=> (rxFull && rxBuf == $past(rxData)))
        else $error("frame not moved to buffer");
endmodule

// ==== test/usdp_partner.sv ====
// far-end serial port: decodes frames off our output, sends frames into our input
module usdp_partner #(
    parameter int BIT_CYC = 16
) (
    input wire logic sys_clk,
    input wire logic txWire,
    input wire logic [3:0] rxLen,
    output logic rxLine
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] got[$];
    logic [11:0] cap;
    // idle line sits high between frames
    initial rxLine = 1'b1;
    // find start, move to mid bit, then sample each bit once
    initial begin
        forever begin
            @(posedge sys_clk);
            if (txWire === 1'b0) begin
                repeat (BIT_CYC / 2) @(posedge sys_clk);
                cap = '1;
                for (int i = 0; i < rxLen; i++) begin
                    repeat (BIT_CYC) @(posedge sys_clk);
                    cap[i] = txWire;
                end
                got.push_back(cap);
            end
        end
    end
    // start low, then bits lsb first, stops already in bits
    task automatic send(input logic [11:0] bits, input int len);
        rxLine <= 1'b0;
        repeat (BIT_CYC) @(posedge sys_clk);
        for (int i = 0; i < len; i++) begin
            rxLine <= bits[i];
            repeat (BIT_CYC) @(posedge sys_clk);
        end
        rxLine <= 1'b1;
    endtask
endmodule

// ==== test/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import usdp_pkg::*;
    logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, completeIrqAck = 0, slv;
    logic [4:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, txOut, txOeN, rxOwned, emptyIrq, completeIrq, rxLine, txWire, xckOut, xckOeN;
    logic [3:0] rxLen = 4'h9;
    int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 32'h4520;
    // released output floats to the pull-up level
    assign txWire = txOeN ? 1'b1 : txOut;

    usdp_datapath dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serialOutputPin(txOut), .serialOutputPinOeN(txOeN), .serialInputPin(rxLine),
        .serialInputOwned(rxOwned), .serialClockPinIn(xckOut), .serialClockPinOut(xckOut),
        .serialClockPinOeN(xckOeN), .completeIrqAck(completeIrqAck), .emptyIrq(emptyIrq), .completeIrq(completeIrq));
    usdp_partner partner (.sys_clk(sys_clk), .txWire(txWire), .rxLen(rxLen), .rxLine(rxLine));

    // ************************************************************
    // clock, watchdog, helpers
    // ************************************************************
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; an idle edge after it keeps drivers single per step
    task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // bits after the start bit: data lsb first, parity, stops high
    function automatic logic [11:0] mkFrame(input logic [8:0] d, input int n, input bit pe, input bit odd);
        logic p;
        logic [11:0] f;
        f = '1;
        p = odd;
        for (int i = 0; i < n; i++) begin
            f[i] = d[i];
            p ^= d[i];
        end
        if (pe) f[n] = p;
        return f;
    endfunction

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int n;
        bit pe, odd, two;
        logic [2:0] code;
        logic [8:0] d [2];
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        apb(0, ADDR_STATA, 0);
        chk("status reset", 32'h20, q);
        chk("out enable reset", 32'h1, 32'(txOeN));
        apb(1, ADDR_BAUD, 0);
        apb(1, ADDR_CTRLB, 32'h78);
        // effective enable lands on the idle edge; look one edge later
        @(posedge sys_clk);
        chk("pin owners", 32'h3, 32'({txOeN, txOut, rxOwned}));
        chk("empty irq", 32'h1, 32'(emptyIrq));
        apb(0, 5'h14, 0);
        chk("unmapped", 32'h80000000, {slv, q[30:0]});
        // size codes 0 to 3 and the nine-bit code, parity off/even/odd, one and two stops
        for (int i = 0; i < 5; i++) begin
            code = (i == 4) ? SIZE_NINE : 3'(i);
            n = (i == 4) ? 9 : 5 + i;
            pe = (i % 3) != 0;
            odd = (i % 3) == 2;
            two = i[0];
            rxLen <= 4'(n + 1 + int'(pe) + int'(two));
            apb(1, ADDR_CTRLC, {24'h0, 2'b00, pe, odd, two, code[1:0], 1'b0});
            for (int j = 0; j < 2; j++) begin
                d[j] = 9'($random(seed));
                apb(1, ADDR_CTRLB, {24'h0, 5'b01111, code[2], 1'b0, d[j][8]});
                apb(1, ADDR_DATA, {23'h0, d[j]});
            end
            apb(0, ADDR_STATA, 0);
            chk("status busy", 32'h0, q & 32'h60);
            while (partner.got.size() < 2) @(posedge sys_clk);
            for (int j = 0; j < 2; j++) begin
                chk("tx frame", 32'(mkFrame(d[j], n, pe, odd)), 32'(partner.got.pop_front()));
            end
            while (completeIrq !== 1'b1) @(posedge sys_clk);
            apb(0, ADDR_STATA, 0);
            chk("status done", 32'h60, q & 32'he0);
            if (i[0]) begin
                completeIrqAck <= 1'b1;
                @(posedge sys_clk);
                completeIrqAck <= 1'b0;
            end else begin
                apb(1, ADDR_STATA, 32'h40);
            end
            apb(0, ADDR_STATA, 0);
            chk("done cleared", 32'h20, q & 32'he0);
            d[0] = 9'($random(seed));
            partner.send(mkFrame(d[0], n, pe, odd), n + 2 + int'(pe));
            while (q[7] !== 1'b1) apb(0, ADDR_STATA, 0);
            apb(0, ADDR_DATA, 0);
            chk("rx data", 32'(d[0] & ((9'h1 << n) - 9'h1)) & 32'hff, q);
            apb(0, ADDR_STATA, 0);
            chk("rx flag", 32'h0, q & 32'h80);
        end
        // disable mid-frame: pin held until the frame is out
        rxLen <= 4'h9;
        // back to eight bits: the nine-bit loop left size bit two set
        apb(1, ADDR_CTRLB, 32'h78);
        apb(1, ADDR_CTRLC, 32'h06);
        apb(1, ADDR_DATA, 32'h5a);
        apb(1, ADDR_CTRLB, 32'h70);
        repeat (20) @(posedge sys_clk);
        chk("held pin", 32'h0, 32'(txOeN));
        while (partner.got.size() < 1) @(posedge sys_clk);
        chk("last frame", 32'hf5a, 32'(partner.got.pop_front()));
        repeat (20) @(posedge sys_clk);
        chk("released pin", 32'h1, 32'(txOeN));
        // sync master: clock pin taken and toggling every tick with divisor zero
        apb(1, ADDR_CTRLC, 32'hc6);
        chk("clock pin enable", 32'h0, 32'(xckOeN));
        q = 32'(xckOut);
        @(posedge sys_clk);
        chk("clock pin toggle", q ^ 32'h1, 32'(xckOut));
        end_of_test();
    end
endmodule
